// ==== src/spi_frame_pkg.sv ====
// Summary of operation
// - Select fall starts frame, rise ends it.
// - Sample input on rising, shift output falling.
// - Under 16 bits: discard, flag error next.
// - Over 16 bits accepted for daisy chains.
// - Command: write flag, address, data, parity, toggle.
// - Odd parity over bits 15 to 1.
// - Expected toggle bit is 0 after reset.
// - Wrong toggle bit flags error next reply.
// - Reply: error, address, data, parity, toggle.
// - Reply answers the previous frame's command.
// - Fallback mode blocks write commands.
// - Sleep ignores frames, output stays undriven.
`default_nettype none
package spi_frame_pkg;
  localparam int FRAME_BITS = 16;
  localparam logic [4:0] FRAME_LEN = 5'h10;
  localparam logic [4:0] CNT_SAT = 5'h11;
  localparam int POS_RW = 15;
  localparam int POS_ADDR = 10;
  localparam int POS_DATA = 2;
  localparam int POS_PAR = 1;
  localparam int POS_TGL = 0;
  localparam logic TGL_RESET = 1'b0;
  localparam logic [15:0] REPLY_RESET = 16'h0000;
  // Register byte addresses on the system bus.
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_MASK = 8'h08;
  localparam logic [7:0] ADR_LAST = 8'h0C;
  localparam logic [7:0] ADR_LINK = 8'h10;
  // Control bits.
  localparam int CTRL_SLEEP = 0;
  localparam int CTRL_LIMP = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  // Event bits shared by status and mask.
  localparam int EV_OK = 0;
  localparam int EV_ERR = 1;
  localparam int EV_BLOCK = 2;
  localparam logic [2:0] EV_RESET = 3'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WRITE = 2'b01,
    ST_WAIT = 2'b10,
    ST_BUILD = 2'b11
  } frame_st_t;
endpackage
`default_nettype wire

// ==== src/spi_reg_mem.sv ====
`default_nettype none
// Thirty-two eight-bit device registers with a registered read port.
module spi_reg_mem
  import spi_frame_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_we,
  input wire logic [4:0] i_waddr,
  input wire logic [7:0] i_wdata,
  input wire logic [4:0] i_raddr,
  output logic [7:0] o_rdata
);
  logic [7:0] mem [0:31];
  // Write and read each take one edge; a read sees a write one cycle later.
  always_ff @(posedge i_clk)
  begin
    if (i_we)
    begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end
endmodule
`default_nettype wire

// ==== src/safety_spi_slave_frame_logic.sv ====
`default_nettype none
// Serial slave frame logic with a bus slave for control and interrupts.
module safety_spi_slave_frame_logic
  import spi_frame_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_RST_B,
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  output logic [31:0] O_HRDATA,
  output logic O_HREADYOUT,
  output logic O_HRESP,
  output logic O_IRQ,
  input wire logic I_SCLK,
  input wire logic I_CHIP_SELECT_N,
  input wire logic I_MOSI,
  output logic O_MISO,
  output logic O_MISO_OE
);
  typedef struct packed {
    logic sclk_m;
    logic sclk_s;
    logic sclk_d;
    logic cs_m;
    logic cs_s;
    logic cs_d;
    logic mosi_m;
    logic mosi_s;
    logic in_bit;
    logic [15:0] rx;
    logic [15:0] tx;
    logic [4:0] cnt;
    logic exp_tgl;
    logic err_pend;
    frame_st_t st;
    logic [15:0] frame;
    logic [15:0] reply;
    logic [15:0] last;
    logic [1:0] ctrl;
    logic [2:0] sts;
    logic [2:0] mask;
    logic a_act;
    logic a_wr;
    logic [7:0] a_addr;
    logic [31:0] hrdata;
  } state_t;

  state_t s_r;
  state_t s_nxt;
  logic [7:0] mem_rdata;
  logic mem_we;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;
  logic in_frame;
  logic sleep;
  logic limp;
  logic [2:0] ev;
  logic [2:0] w1c;

  // Odd parity: the check bit, taken over bits 15..2, makes the ones over bits 15..1 odd.
  function automatic logic odd_bit(input logic [13:0] bits);
    odd_bit = ~(^bits);
  endfunction

  // Selects one of the own bus registers.
  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction

  // Command store, addressed by the last valid frame for both write and read.
  spi_reg_mem spi_reg_mem_i (
    .i_clk(I_CLK),
    .i_we(mem_we),
    .i_waddr(s_r.frame[POS_ADDR +: 5]),
    .i_wdata(s_r.frame[POS_DATA +: 8]),
    .i_raddr(s_r.frame[POS_ADDR +: 5]),
    .o_rdata(mem_rdata)
  );

  // Edge detection works only on the second synchroniser stage.
  assign sleep = s_r.ctrl[CTRL_SLEEP];
  assign limp = s_r.ctrl[CTRL_LIMP];
  assign in_frame = ~s_r.cs_s & ~sleep;
  assign sclk_rise = s_r.sclk_s & ~s_r.sclk_d & in_frame;
  assign sclk_fall = ~s_r.sclk_s & s_r.sclk_d & in_frame;
  assign cs_fall = ~s_r.cs_s & s_r.cs_d;
  assign cs_rise = s_r.cs_s & ~s_r.cs_d;
  // Fallback keeps the frame valid but holds the store's write strobe low.
  assign mem_we = (s_r.st == ST_WRITE) && s_r.frame[POS_RW] && !limp;

  // Next-state logic of the whole block.
  always_comb
  begin
    s_nxt = s_r;
    ev = 3'h0;
    w1c = 3'h0;
    // Two-stage synchronisers for the link pins.
    s_nxt.sclk_m = I_SCLK;
    s_nxt.sclk_s = s_r.sclk_m;
    s_nxt.sclk_d = s_r.sclk_s;
    s_nxt.cs_m = I_CHIP_SELECT_N;
    s_nxt.cs_s = s_r.cs_m;
    s_nxt.cs_d = s_r.cs_s;
    s_nxt.mosi_m = I_MOSI;
    s_nxt.mosi_s = s_r.mosi_m;

    // Frame start loads the answer to the previous command.
    if (cs_fall && !sleep)
    begin
      s_nxt.tx = s_r.reply;
      s_nxt.cnt = 5'h00;
    end
    // Capture on rising serial clock edges, keeping the last 16 bits.
    if (sclk_rise)
    begin
      s_nxt.rx = {s_r.rx[14:0], s_r.mosi_s};
      s_nxt.in_bit = s_r.mosi_s;
      // The count saturates, so any frame of 16 or more bits passes.
      if (s_r.cnt != CNT_SAT)
      begin
        s_nxt.cnt = s_r.cnt + 5'h01;
      end
    end
    // Shift out on falling edges; captured bits follow so a chain passes through.
    if (sclk_fall)
    begin
      s_nxt.tx = {s_r.tx[14:0], s_r.in_bit};
    end

    // Frame end checks length, parity and toggle bit.
    if (cs_rise && !sleep && s_r.st == ST_IDLE)
    begin
      // Only the first failing check counts; all share one error flag.
      if (s_r.cnt < FRAME_LEN)
      begin
        s_nxt.err_pend = 1'b1;
        s_nxt.st = ST_BUILD;
        ev[EV_ERR] = 1'b1;
      end
      else if (odd_bit(s_r.rx[15:2]) != s_r.rx[POS_PAR])
      begin
        s_nxt.err_pend = 1'b1;
        s_nxt.st = ST_BUILD;
        ev[EV_ERR] = 1'b1;
      end
      else if (s_r.rx[POS_TGL] != s_r.exp_tgl)
      begin
        s_nxt.err_pend = 1'b1;
        s_nxt.st = ST_BUILD;
        ev[EV_ERR] = 1'b1;
      end
      else
      begin
        s_nxt.frame = s_r.rx;
        s_nxt.last = s_r.rx;
        s_nxt.exp_tgl = ~s_r.exp_tgl;
        s_nxt.err_pend = 1'b0;
        s_nxt.st = ST_WRITE;
        ev[EV_OK] = 1'b1;
      end
    end

    // Execute, wait for read data, then build the reply.
    case (s_r.st)
      ST_IDLE:
      begin
        // Waits for a frame end; the checks above move the state on.
      end
      ST_WRITE:
      begin
        // A blocked write is only reported, never executed.
        if (s_r.frame[POS_RW] && limp)
        begin
          ev[EV_BLOCK] = 1'b1;
        end
        s_nxt.st = ST_WAIT;
      end
      ST_WAIT:
      begin
        // The read port shows a fresh write only one edge later.
        s_nxt.st = ST_BUILD;
      end
      ST_BUILD:
      begin
        if (s_r.err_pend)
        begin
          // A failed frame keeps the old address and sends no data.
          s_nxt.reply[15] = 1'b1;
          s_nxt.reply[POS_DATA +: 8] = 8'h00;
        end
        else
        begin
          s_nxt.reply[15] = 1'b0;
          s_nxt.reply[POS_ADDR +: 5] = s_r.frame[POS_ADDR +: 5];
          s_nxt.reply[POS_DATA +: 8] = mem_rdata;
        end
        s_nxt.reply[POS_TGL] = s_r.exp_tgl;
        s_nxt.st = ST_IDLE;
      end
      default:
      begin
        // Unused codes fall back to idle.
        s_nxt.st = ST_IDLE;
      end
    endcase
    // The check bit is made last, over the reply fields just built.
    if (s_r.st == ST_BUILD)
    begin
      s_nxt.reply[POS_PAR] = odd_bit(s_nxt.reply[15:2]);
    end

    // Bus address phase is captured; reads answer from a register.
    s_nxt.a_act = 1'b0;
    if (I_HSEL && I_HREADY && I_HTRANS == HTRANS_NONSEQ)
    begin
      s_nxt.a_act = 1'b1;
      s_nxt.a_wr = I_HWRITE;
      s_nxt.a_addr = I_HADDR[7:0];
      if (!I_HWRITE)
      begin
        s_nxt.hrdata = 32'h0000_0000;
        if (hit(I_HADDR[7:0], ADR_CTRL))
        begin
          s_nxt.hrdata[1:0] = s_r.ctrl;
        end
        if (hit(I_HADDR[7:0], ADR_STATUS))
        begin
          s_nxt.hrdata[2:0] = s_r.sts;
        end
        if (hit(I_HADDR[7:0], ADR_MASK))
        begin
          s_nxt.hrdata[2:0] = s_r.mask;
        end
        if (hit(I_HADDR[7:0], ADR_LAST))
        begin
          s_nxt.hrdata[15:0] = s_r.last;
        end
        if (hit(I_HADDR[7:0], ADR_LINK))
        begin
          s_nxt.hrdata[2:0] = {s_r.cs_s, s_r.err_pend, s_r.exp_tgl};
        end
      end
    end
    // Bus data phase of a write.
    if (s_r.a_act && s_r.a_wr)
    begin
      if (hit(s_r.a_addr, ADR_CTRL))
      begin
        s_nxt.ctrl = I_HWDATA[1:0];
      end
      if (hit(s_r.a_addr, ADR_MASK))
      begin
        s_nxt.mask = I_HWDATA[2:0];
      end
      if (hit(s_r.a_addr, ADR_STATUS))
      begin
        w1c = I_HWDATA[2:0];
      end
    end
    // A new event wins over a clear in the same cycle.
    s_nxt.sts = (s_r.sts & ~w1c) | ev;
  end

  // The single state register of the block.
  always_ff @(posedge I_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      s_r <= '0;
      // Select stages reset high so no false frame edge follows reset.
      s_r.sclk_m <= 1'b0;
      s_r.cs_m <= 1'b1;
      s_r.cs_s <= 1'b1;
      s_r.cs_d <= 1'b1;
      s_r.exp_tgl <= TGL_RESET;
      s_r.reply <= REPLY_RESET;
      s_r.ctrl <= CTRL_RESET;
      s_r.sts <= EV_RESET;
      s_r.mask <= EV_RESET;
      s_r.st <= ST_IDLE;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // Outputs: data from flip-flops, output enable only inside a frame.
  assign O_MISO = s_r.tx[15];
  assign O_MISO_OE = in_frame;
  assign O_HRDATA = s_r.hrdata;
  // The bus never stalls and always answers OKAY.
  assign O_HREADYOUT = 1'b1;
  assign O_HRESP = 1'b0;
  assign O_IRQ = |(s_r.sts & s_r.mask);
endmodule
`default_nettype wire

// ==== testbench/spi_frame_assertions.sv ====
`default_nettype none
// Port-level checks of the serial frame block.
module spi_frame_assertions
  import spi_frame_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_RST_B,
  input wire logic I_HSEL,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic I_HREADY,
  input wire logic I_SCLK,
  input wire logic I_CHIP_SELECT_N,
  input wire logic [31:0] O_HRDATA,
  input wire logic O_HREADYOUT,
  input wire logic O_HRESP,
  input wire logic O_IRQ,
  input wire logic O_MISO,
  input wire logic O_MISO_OE
);
  logic cs_q;
  logic [4:0] age_r;
  wire logic rd_take = I_HSEL && I_HREADY && I_HTRANS == HTRANS_NONSEQ && !I_HWRITE;
  wire logic wr_take = I_HSEL && I_HREADY && I_HTRANS == HTRANS_NONSEQ && I_HWRITE;
  // Counts cycles since the last bus write or frame end, as the IRQ only moves after one.
  always_ff @(posedge I_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      cs_q <= 1'b1;
      age_r <= 5'h1F;
    end
    else
    begin
      cs_q <= I_CHIP_SELECT_N;
      if (wr_take || (I_CHIP_SELECT_N && !cs_q))
        age_r <= 5'h00;
      else if (age_r != 5'h1F)
        age_r <= age_r + 5'h01;
    end
  end
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RST_B);
  sequence cs_idle;
    I_CHIP_SELECT_N [*4];
  endsequence
  sequence sck_high;
    (I_SCLK && !I_CHIP_SELECT_N) [*4];
  endsequence
  AST_HREADY: assert property (O_HREADYOUT) else $error("bus stalled");
  AST_HRESP: assert property (!O_HRESP) else $error("bus error response");
  AST_HRDATA_HOLD: assert property (!$past(rd_take) |-> $stable(O_HRDATA))
    else $error("read data moved without a read");
  AST_OE_IDLE: assert property (cs_idle |-> !O_MISO_OE)
    else $error("output driven outside a frame");
  AST_OE_RISE: assert property ($rose(O_MISO_OE) |-> !$past(I_CHIP_SELECT_N, 2))
    else $error("output enabled without select");
  AST_OE_FALL: assert property ($fell(O_MISO_OE) |-> $past(I_CHIP_SELECT_N, 2))
    else $error("output released inside a frame");
  AST_MISO_HOLD: assert property (sck_high |-> $stable(O_MISO))
    else $error("serial output moved while clock high");
  AST_IRQ_CAUSE: assert property ($changed(O_IRQ) |-> age_r < 5'h10)
    else $error("interrupt moved without a cause");
endmodule
bind safety_spi_slave_frame_logic spi_frame_assertions spi_frame_assertions_i (.*);
`default_nettype wire

// ==== testbench/spi_master_model.sv ====
`default_nettype none
// Far-side bus master: mode 0, 160 ns clock, MSB first, clock and data idle low.
module spi_master_model
(
  input wire logic i_clk,
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_mosi,
  input wire logic i_miso
);
  timeunit 1ns;
  timeprecision 1ps;
  // Select pulled up, clock and data pulled down while no frame runs.
  initial
  begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
  end
  // One framed transfer paced by the system clock, eight clocks per half link period.
  // Data changes with the falling link clock; the reply is taken as the clock rises.
  task automatic frame(input int n, input logic [31:0] tx, output logic [31:0] rx);
    rx = 32'h0;
    @(posedge i_clk);
    o_cs_n <= 1'b0;
    repeat (20) @(posedge i_clk);
    for (int i = n - 1; i >= 0; i--)
    begin
      o_mosi <= tx[i];
      repeat (8) @(posedge i_clk);
      o_sclk <= 1'b1;
      rx = {rx[30:0], i_miso};
      repeat (8) @(posedge i_clk);
      o_sclk <= 1'b0;
    end
    repeat (20) @(posedge i_clk);
    o_cs_n <= 1'b1;
    o_mosi <= 1'b0;
    repeat (70) @(posedge i_clk);
  endtask
endmodule
`default_nettype wire

// ==== testbench/test_safety_spi_slave_frame_logic.sv ====
`default_nettype none
// Self-checking bench for the serial frame block.
module test_safety_spi_slave_frame_logic
  import spi_frame_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rdata, rx;
  logic last_q = 1'b0, tg = 1'b0;
  wire logic [31:0] hrdata;
  wire logic hready, irq, miso, oe, sclk, cs_n, mosi;
  int num_errors = 0, num_checks = 0, oe_cnt = 0, n0;
  wire logic miso_w = oe ? miso : ~last_q;
  always #5 clk = ~clk;
  // A released return line shows the inverse of its last level; enables are counted.
  always @(posedge clk)
  begin
    if (oe) last_q <= miso;
    oe_cnt <= oe_cnt + int'(oe);
  end
  safety_spi_slave_frame_logic safety_spi_slave_frame_logic_i (.I_CLK(clk), .I_RST_B(rst_b),
    .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2),
    .I_HWDATA(hwdata), .I_HREADY(hready), .O_HRDATA(hrdata), .O_HREADYOUT(hready),
    .O_HRESP(), .O_IRQ(irq), .I_SCLK(sclk), .I_CHIP_SELECT_N(cs_n), .I_MOSI(mosi),
    .O_MISO(miso), .O_MISO_OE(oe));
  spi_master_model spi_master_model_i (.i_clk(clk), .o_sclk(sclk), .o_cs_n(cs_n),
    .o_mosi(mosi), .i_miso(miso_w));
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {24'h000000, a};
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rdata = hrdata;
  endtask
  function automatic logic [15:0] frm(logic b, logic [4:0] a, logic [7:0] d, logic t);
    return {b, a, d, ~^{b, a, d}, t};
  endfunction
  task automatic xfer(input int n, input logic [31:0] tx);
    spi_master_model_i.frame(n, tx, rx);
    @(posedge clk);
  endtask
  task automatic irq_is(input logic e);
    repeat (2) @(posedge clk);
    chk("irq", irq, e);
  endtask
  task automatic t_reset;
    for (int a = 0; a < 6; a++)
    begin
      ahb(1'b0, 8'(4 * a), 32'h0);
      // The link word shows the idle select high in its bit 2.
      chk("reg", rdata, (a == 4) ? 32'h0000_0004 : 32'h0);
    end
  endtask
  task automatic t_basic;
    ahb(1'b1, ADR_MASK, 32'h2);
    xfer(16, frm(1'b1, 5'h03, 8'hA5, tg));
    chk("first", rx, REPLY_RESET);
    irq_is(1'b0);
    tg = ~tg;
    xfer(16, frm(1'b0, 5'h03, 8'h00, tg));
    chk("echo", rx, frm(1'b0, 5'h03, 8'hA5, tg));
    tg = ~tg;
  endtask
  task automatic t_err(input int n, input logic [31:0] bad);
    xfer(n, bad);
    irq_is(1'b1);
    ahb(1'b1, ADR_STATUS, 32'h2);
    irq_is(1'b0);
    xfer(16, frm(1'b0, 5'h03, 8'h00, tg));
    chk("err", {rx[15], rx[9:2], rx[0]}, {1'b1, 8'h00, tg});
    chk("par", ^rx[15:1], 1'b1);
    tg = ~tg;
    xfer(16, frm(1'b0, 5'h03, 8'h00, tg));
    chk("ok", rx, frm(1'b0, 5'h03, 8'hA5, tg));
    tg = ~tg;
  endtask
  task automatic t_long;
    xfer(24, {8'hFF, frm(1'b1, 5'h03, 8'h5A, tg)});
    chk("chain", rx, {frm(1'b0, 5'h03, 8'hA5, tg), 8'hFF});
    tg = ~tg;
    xfer(16, frm(1'b0, 5'h03, 8'h00, tg));
    chk("last", rx, frm(1'b0, 5'h03, 8'h5A, tg));
    tg = ~tg;
  endtask
  task automatic t_modes;
    ahb(1'b1, ADR_CTRL, 32'h2);
    xfer(16, frm(1'b1, 5'h03, 8'h11, tg));
    tg = ~tg;
    ahb(1'b0, ADR_STATUS, 32'h0);
    chk("block", rdata[EV_BLOCK], 1'b1);
    ahb(1'b1, ADR_CTRL, 32'h1);
    n0 = oe_cnt;
    xfer(16, frm(1'b1, 5'h03, 8'h22, tg));
    chk("hiz", oe_cnt - n0, 32'h0);
    ahb(1'b1, ADR_CTRL, 32'h0);
    xfer(16, frm(1'b0, 5'h03, 8'h00, tg));
    chk("modes", rx, frm(1'b0, 5'h03, 8'h5A, tg));
  endtask
  task report_and_stop;
    if (num_errors == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Main sequence: reset, then one task per scenario.
  initial
  begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset;
    t_basic;
    t_err(16, frm(1'b0, 5'h03, 8'h00, ~tg));
    t_err(16, frm(1'b0, 5'h03, 8'h00, tg) ^ 16'h0002);
    t_err(12, 32'h123);
    t_long;
    t_modes;
    report_and_stop;
  end
  // Cuts a hang short well beyond the expected run time.
  initial
  begin
    #500us;
    num_errors++;
    report_and_stop;
  end
endmodule
`default_nettype wire
